// >>> dccrb_bank.sv
// Host-visible control register bank of the acquisition card
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Enable bit resets low, gating digital I/O
// - Mask bits 1..0 enable sources, reset zero
// - Polarity zero inverts, one passes; upper zero
// - Status shows sources, EEPROM state, board ident
// - Extension control byte read/write, internal use
// - EEPROM data byte read/write, drives EEPROM pins
// - Timer counters RW, control word write-only
// - Converter and digital bytes decoded from base
// - Acquisition control writes, status read-only
module dccrb_bank
  import dccrb_pkg::*;
#(
  parameter logic [3:0] BOARD_IDENT = 4'h5  // Arbitrary value
) (
  input  wire logic        i_mclk,              // System clock, 10 MHz
  input  wire logic        i_rst_n,             // Async reset, active low
  input  wire logic [15:0] i_io_addr,           // Host I/O address
  input  wire logic [15:0] i_io_base_address,   // Assigned base
  input  wire logic        i_io_rd,             // Read strobe, one cycle
  input  wire logic        i_io_wr,             // Write strobe, one cycle
  input  wire logic [7:0]  i_io_wdata,          // Write byte
  output logic [7:0]       o_io_rdata,          // Read byte
  output logic             o_io_rd_valid,       // Read answer pulse
  input  wire logic        i_irq_source_0,      // Interrupt source 0 pin
  input  wire logic        i_irq_source_1,      // Interrupt source 1 pin
  output logic             o_irq,               // Host interrupt line
  input  wire logic [1:0]  i_eeprom_state,      // EEPROM control pins
  output logic [7:0]       o_extension_control, // Extension control
  output logic [7:0]       o_eeprom_data_ctrl,  // EEPROM control lines
  output logic             o_board_enable,      // Board enable level
  input  wire logic [23:0] i_timer_rdata,       // Counters 2..0 bytes
  output logic             o_timer_wr,          // Timer write pulse
  output logic [1:0]       o_timer_port,        // Timer port index
  output logic [7:0]       o_timer_wdata,       // Timer write byte
  input  wire logic [11:0] i_adc_data,          // Converter result
  input  wire logic        i_adc_ready,         // Conversion done
  output logic [11:0]      o_dac_data,          // Output converter word
  output logic             o_dac_load,          // Output word updated
  input  wire logic [15:0] i_digital_in,        // Digital input pins
  output logic [15:0]      o_digital_out,       // Digital output pins
  output logic [7:0]       o_gain_channel,      // Gain and channel
  output logic [7:0]       o_conv_mode,         // Conversion mode
  output logic             o_soft_trigger       // Trigger pulse
);

  // ==========================================================
  // Address decode
  logic [16:0] rel;
  logic        hit;
  logic [7:0]  off;
  logic        rd_go;
  logic        wr_go;

  // The base is whatever firmware assigned; only the offset matters
  assign rel   = dccrb_rel(i_io_addr, i_io_base_address);
  assign hit   = rel[16];
  assign off   = rel[7:0];
  assign rd_go = i_io_rd && hit;
  assign wr_go = i_io_wr && hit;

  // Write selects
  logic w_en;
  logic w_ext;
  logic w_ee;
  logic w_mask;
  logic w_pol;
  logic w_timer;
  logic w_dac_lo;
  logic w_dac_hi;
  logic w_do_lo;
  logic w_do_hi;
  logic w_gain;
  logic w_mode;
  logic w_trig;

  assign w_en     = wr_go && (off == DCCRB_OFF_BOARD_EN);
  assign w_ext    = wr_go && (off == DCCRB_OFF_EXT_CTRL);
  assign w_ee     = wr_go && (off == DCCRB_OFF_EE_DATA);
  assign w_mask   = wr_go && (off == DCCRB_OFF_IRQ_MASK);
  assign w_pol    = wr_go && (off == DCCRB_OFF_IRQ_POL);
  // All four timer ports accept writes, the fourth being the control word
  assign w_timer  = wr_go && (off[7:4] == 4'hc) && (off[1:0] == 2'h0);
  assign w_dac_lo = wr_go && (off == DCCRB_OFF_CONV_LO);
  assign w_dac_hi = wr_go && (off == DCCRB_OFF_CONV_HI);
  assign w_do_lo  = wr_go && (off == DCCRB_OFF_DIO_LO);
  assign w_do_hi  = wr_go && (off == DCCRB_OFF_DIO_HI);
  assign w_gain   = wr_go && (off == DCCRB_OFF_GAIN_SEL);
  assign w_mode   = wr_go && (off == DCCRB_OFF_CONV_MODE);
  assign w_trig   = wr_go && (off == DCCRB_OFF_SOFT_TRIG);

  // ==========================================================
  // Interrupt unit
  dccrb_irq_if irq_bus ();

  assign irq_bus.mask_wr = w_mask;
  assign irq_bus.pol_wr  = w_pol;
  assign irq_bus.wdata   = i_io_wdata;

  dccrb_irq_unit u_irq (
    .i_mclk         (i_mclk),
    .i_rst_n        (i_rst_n),
    .i_irq_source_0 (i_irq_source_0),
    .i_irq_source_1 (i_irq_source_1),
    .bus            (irq_bus.unit),
    .o_irq          (o_irq)
  );

  // ==========================================================
  // Pin synchroniser for digital inputs and EEPROM state
  logic [17:0] ps1_q;
  logic [17:0] ps2_q;
  logic [17:0] ps3_q;
  logic [17:0] pin_q;

  // Stage 1 feeds only stage 2; filtering waits for stages 2 and 3
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ps1_q <= 18'h00000;
      ps2_q <= 18'h00000;
      ps3_q <= 18'h00000;
    end else begin
      ps1_q <= {i_eeprom_state, i_digital_in};
      ps2_q <= ps1_q;
      ps3_q <= ps2_q;
    end
  end

  // Accept each bit only when two stages agree
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_q <= 18'h00000;
    end else begin
      pin_q <= (ps2_q & ps3_q) | (pin_q & (ps2_q | ps3_q));
    end
  end

  // ==========================================================
  // Control registers
  logic        en_q;
  logic [7:0]  ext_q;
  logic [7:0]  ee_q;
  logic [7:0]  dac_lo_q;
  logic [11:0] dac_q;
  logic        dac_ld_q;
  logic [15:0] dout_q;
  logic [7:0]  gain_q;
  logic [7:0]  mode_q;
  logic        trig_q;

  // Board enable starts low after power-up
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_q <= 1'b0;
    end else if (w_en) begin
      en_q <= i_io_wdata[DCCRB_BOARD_EN_BIT];
    end
  end

  // Extension and EEPROM bytes are plain read/write storage
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_q <= DCCRB_RST_BYTE;
      ee_q  <= DCCRB_RST_BYTE;
    end else begin
      if (w_ext) begin
        ext_q <= i_io_wdata;
      end
      if (w_ee) begin
        ee_q <= i_io_wdata;
      end
    end
  end

  // Double-buffered output converter: low byte is held until the
  // high byte lands, so the analogue output never shows a torn word.
  // Enabling the board first is software's duty, not gated here.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dac_lo_q <= DCCRB_RST_BYTE;
      dac_q    <= DCCRB_RST_DAC;
      dac_ld_q <= 1'b0;
    end else begin
      dac_ld_q <= w_dac_hi;
      if (w_dac_lo) begin
        dac_lo_q <= i_io_wdata;
      end
      if (w_dac_hi) begin
        dac_q <= {i_io_wdata[3:0], dac_lo_q};
      end
    end
  end

  // Digital outputs clear and ignore writes while the board is disabled
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dout_q <= DCCRB_RST_DOUT;
    end else if (!en_q) begin
      dout_q <= DCCRB_RST_DOUT;
    end else begin
      if (w_do_lo) begin
        dout_q[7:0] <= i_io_wdata;
      end
      if (w_do_hi) begin
        dout_q[15:8] <= i_io_wdata;
      end
    end
  end

  // Acquisition control bytes; the trigger is a single-cycle pulse
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gain_q <= DCCRB_RST_BYTE;
      mode_q <= DCCRB_RST_BYTE;
      trig_q <= 1'b0;
    end else begin
      trig_q <= w_trig && i_io_wdata[DCCRB_SOFT_TRIG_BIT];
      if (w_gain) begin
        gain_q <= i_io_wdata;
      end
      if (w_mode) begin
        mode_q <= i_io_wdata;
      end
    end
  end

  // Timer writes are forwarded as a registered port access
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_timer_wr    <= 1'b0;
      o_timer_port  <= 2'h0;
      o_timer_wdata <= DCCRB_RST_BYTE;
    end else begin
      o_timer_wr <= w_timer;
      if (w_timer) begin
        o_timer_port  <= off[3:2];
        o_timer_wdata <= i_io_wdata;
      end
    end
  end

  // ==========================================================
  // Read path
  logic [7:0]  stat_byte;
  logic [7:0]  timer_byte;
  logic [15:0] din_gated;
  logic [7:0]  rd_mux;

  // Status: sources, EEPROM pins, fixed board ident nibble
  assign stat_byte  = {BOARD_IDENT, pin_q[17:16], irq_bus.src};
  assign timer_byte = i_timer_rdata[{off[3:2], 3'b000} +: 8];
  // Digital inputs read zero while the board is disabled
  assign din_gated  = en_q ? pin_q[15:0] : 16'h0000;

  // Reserved reads and unmapped offsets return zero
  assign rd_mux =
    (off == DCCRB_OFF_BOARD_EN)  ? {7'h00, en_q} :
    (off == DCCRB_OFF_EXT_CTRL)  ? ext_q :
    (off == DCCRB_OFF_EE_DATA)   ? ee_q :
    (off == DCCRB_OFF_IRQ_MASK)  ? {6'h00, irq_bus.mask} :
    (off == DCCRB_OFF_PIN_STAT)  ? stat_byte :
    (off == DCCRB_OFF_IRQ_POL)   ? {6'h00, irq_bus.pol} :
    (off == DCCRB_OFF_TIMER_C0)  ? timer_byte :
    (off == DCCRB_OFF_TIMER_C1)  ? timer_byte :
    (off == DCCRB_OFF_TIMER_C2)  ? timer_byte :
    (off == DCCRB_OFF_CONV_LO)   ? i_adc_data[7:0] :
    (off == DCCRB_OFF_CONV_HI)   ? {4'h0, i_adc_data[11:8]} :
    (off == DCCRB_OFF_DIO_LO)    ? din_gated[7:0] :
    (off == DCCRB_OFF_DIO_HI)    ? din_gated[15:8] :
    (off == DCCRB_OFF_CONV_STAT) ? {7'h00, i_adc_ready} :
    8'h00;

  // Answer one cycle after the strobe; a miss still answers with zero
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_io_rdata    <= DCCRB_RST_BYTE;
      o_io_rd_valid <= 1'b0;
    end else begin
      o_io_rd_valid <= i_io_rd;
      if (i_io_rd) begin
        o_io_rdata <= rd_go ? rd_mux : 8'h00;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign o_board_enable      = en_q;
  assign o_extension_control = ext_q;
  assign o_eeprom_data_ctrl  = ee_q;
  assign o_dac_data          = dac_q;
  assign o_dac_load          = dac_ld_q;
  assign o_digital_out       = dout_q;
  assign o_gain_channel      = gain_q;
  assign o_conv_mode         = mode_q;
  assign o_soft_trigger      = trig_q;

endmodule : dccrb_bank
`default_nettype wire

// >>> dccrb_bank_bench.sv
// Self-checking testbench for the control register bank
`timescale 1ns/1ps
`default_nettype none
bind dccrb_bank dccrb_chk chk_u (.i_mclk, .i_rst_n, .i_io_addr,
  .i_io_base_address, .i_io_rd, .i_io_wr, .i_io_wdata, .o_io_rd_valid,
  .o_irq, .o_board_enable, .o_timer_wr, .o_timer_port, .o_timer_wdata,
  .o_dac_load, .o_dac_data, .o_digital_out, .o_soft_trigger);
module dccrb_bank_bench
  import dccrb_pkg::*;
;
  localparam logic [3:0] IDENT = 4'h9; // Arbitrary value
  logic mclk, rst_n, rd, wr, rd_valid, src0, src1, irq, board_en;
  logic timer_wr, adc_ready, dac_load, trig;
  logic [15:0] addr, base, din, dout;
  logic [7:0]  wdata, rdata, ext_ctrl, ee_ctrl, timer_wdata, gain, mode;
  logic [1:0]  ee_state, timer_port;
  logic [23:0] timer_rdata;
  logic [11:0] adc_data, dac_data;
  int n_errors = 0;
  int n_checks = 0;

  dccrb_host host_u (.i_mclk(mclk), .i_rdata(rdata), .o_addr(addr),
    .o_base(base), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
  dccrb_bank #(.BOARD_IDENT(IDENT)) dut_u (.i_mclk(mclk), .i_rst_n(rst_n),
    .i_io_addr(addr), .i_io_base_address(base), .i_io_rd(rd),
    .i_io_wr(wr), .i_io_wdata(wdata), .o_io_rdata(rdata),
    .o_io_rd_valid(rd_valid), .i_irq_source_0(src0),
    .i_irq_source_1(src1), .o_irq(irq), .i_eeprom_state(ee_state),
    .o_extension_control(ext_ctrl), .o_eeprom_data_ctrl(ee_ctrl),
    .o_board_enable(board_en), .i_timer_rdata(timer_rdata),
    .o_timer_wr(timer_wr), .o_timer_port(timer_port),
    .o_timer_wdata(timer_wdata), .i_adc_data(adc_data),
    .i_adc_ready(adc_ready), .o_dac_data(dac_data), .o_dac_load(dac_load),
    .i_digital_in(din), .o_digital_out(dout), .o_gain_channel(gain),
    .o_conv_mode(mode), .o_soft_trigger(trig));

  // ==========================================================
  // Clock, 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] off, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(base + {8'h00, off}, d);
    // The answer pulse stands for one cycle, seen here with the byte
    chk({7'h00, rd_valid, d}, {8'h01, exp});
  endtask : rdchk

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk(board_en, 1'b0);
    rdchk(8'h00, 8'h00);
    rdchk(8'h05, 8'h00);
    rdchk(8'h2a, 8'h00);
  endtask : t_reset

  task automatic t_dio();
    host_u.wr(8'hd8, 8'ha5);
    chk(dout, 16'h0000);
    rdchk(8'hd8, 8'h00);
    host_u.wr(8'h00, 8'h01);
    chk(board_en, 1'b1);
    host_u.wr(8'hd8, 8'ha5);
    host_u.wr(8'hdc, 8'h3c);
    chk(dout, 16'h3ca5);
    rdchk(8'hd8, 8'h34);
    rdchk(8'hdc, 8'h12);
  endtask : t_dio

  task automatic t_regs();
    host_u.wr(8'h05, 8'hff);
    rdchk(8'h05, 8'h03);
    host_u.wr(8'h2a, 8'hff);
    rdchk(8'h2a, 8'h03);
    host_u.wr(8'h02, 8'ha5);
    rdchk(8'h02, 8'ha5);
    chk(ext_ctrl, 8'ha5);
    host_u.wr(8'h03, 8'h5a);
    rdchk(8'h03, 8'h5a);
    chk(ee_ctrl, 8'h5a);
  endtask : t_regs

  // Sources pass a sync chain, so wait before looking
  task automatic t_status();
    src0 = 1'b1;
    ee_state = 2'b10;
    repeat (8) @(posedge mclk);
    rdchk(8'h07, {IDENT, 2'b10, 2'b01});
    host_u.wr(8'h07, 8'h00);
    rdchk(8'h07, {IDENT, 2'b10, 2'b01});
  endtask : t_status

  // Every mask and polarity pair against sources 1 and 0
  task automatic t_irq();
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      host_u.wr(8'h05, {6'h00, c[1:0]});
      host_u.wr(8'h2a, {6'h00, c[3:2]});
      repeat (2) @(posedge mclk);
      #1;
      chk(irq, |((c[3:2] ~^ 2'b01) & c[1:0]));
    end
    // Source 1 alone, passed uninverted and enabled
    src0 = 1'b0;
    src1 = 1'b1;
    host_u.wr(8'h2a, 8'h02);
    host_u.wr(8'h05, 8'h02);
    repeat (8) @(posedge mclk);
    #1;
    chk(irq, 1'b1);
    rdchk(8'h07, {IDENT, 2'b10, 2'b10});
    host_u.wr(8'h05, 8'h00);
  endtask : t_irq

  task automatic t_timer();
    host_u.wr(8'hc0, 8'h11);
    host_u.wr(8'hc8, 8'h33);
    host_u.wr(8'hcc, 8'h34);
    chk({5'h00, timer_wr, timer_port, timer_wdata}, 16'h0734);
    rdchk(8'hc4, 8'h22);
    rdchk(8'hcc, 8'h00);
    rdchk(8'hc1, 8'h00);
  endtask : t_timer

  task automatic t_acq();
    rdchk(8'hd0, 8'hbc);
    rdchk(8'hd4, 8'h0a);
    rdchk(8'hec, 8'h01);
    for (int i = 0; i < 3; i++) rdchk(8'he0 + 8'(4 * i), 8'h00);
    host_u.wr(8'he0, 8'h25);
    chk(gain, 8'h25);
    host_u.wr(8'he4, 8'hf1);
    chk(mode, 8'hf1);
    host_u.wr(8'he8, 8'h01);
    chk(trig, 1'b1);
    host_u.wr(8'hd0, 8'h34);
    host_u.wr(8'hd4, 8'h0c);
    chk({dac_load, dac_data}, 16'h1c34);
  endtask : t_acq

  // Decoding follows a moved base; the old window now misses
  task automatic t_base();
    logic [7:0] d;
    host_u.set_base(16'h1000);
    host_u.wr(8'h05, 8'h02);
    rdchk(8'h05, 8'h02);
    host_u.rd(16'h0305, d);
    chk({7'h00, rd_valid, d}, 16'h0100);
  endtask : t_base

  // ==========================================================
  // Main sequence; all inputs defined from time zero
  initial begin
    rst_n = 1'b0;
    src0 = 1'b0;
    src1 = 1'b0;
    ee_state = 2'b00;
    timer_rdata = 24'h332211;
    adc_data = 12'habc;
    adc_ready = 1'b1;
    din = 16'h1234;
    repeat (10) @(posedge mclk);
    #1 rst_n = 1'b1;
    t_reset();
    t_dio();
    t_regs();
    t_status();
    t_irq();
    t_timer();
    t_acq();
    t_base();
    end_sim();
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #(20000 * 100);
    n_errors++;
    end_sim();
  end
endmodule : dccrb_bank_bench
`default_nettype wire

// >>> dccrb_chk.sv
// Port-level assertion checker for the control register bank
`timescale 1ns/1ps
`default_nettype none
module dccrb_chk
  import dccrb_pkg::*;
(
  input wire logic        i_mclk,            // Clock
  input wire logic        i_rst_n,           // Reset, active low
  input wire logic [15:0] i_io_addr,         // Address
  input wire logic [15:0] i_io_base_address, // Base
  input wire logic        i_io_rd,           // Read strobe
  input wire logic        i_io_wr,           // Write strobe
  input wire logic [7:0]  i_io_wdata,        // Write byte
  input wire logic        o_io_rd_valid,     // Read answer
  input wire logic        o_irq,             // Host line
  input wire logic        o_board_enable,    // Enable level
  input wire logic        o_timer_wr,        // Timer pulse
  input wire logic [1:0]  o_timer_port,      // Timer port
  input wire logic [7:0]  o_timer_wdata,     // Timer byte
  input wire logic        o_dac_load,        // Output word pulse
  input wire logic [11:0] o_dac_data,        // Output word
  input wire logic [15:0] o_digital_out,     // Output pins
  input wire logic        o_soft_trigger     // Trigger pulse
);
  // ==========================================================
  // Decode helper, mirrors the relative window
  wire logic [15:0] rel_w = i_io_addr - i_io_base_address;
  wire logic        hit_w = (i_io_addr >= i_io_base_address) &&
                            (rel_w[15:8] == 8'h00);

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_wr(logic [7:0] off);
    i_io_wr && hit_w && (rel_w[7:0] == off);
  endsequence

  // ==========================================================
  // Bus answer and register side effects
  AST_RD_ANSWER: assert property (i_io_rd |=> o_io_rd_valid)
    else $error("read not answered next cycle");
  AST_RD_QUIET: assert property (!i_io_rd |=> !o_io_rd_valid)
    else $error("answer without read");
  AST_EN_FOLLOW: assert property (s_wr(DCCRB_OFF_BOARD_EN) |=>
    o_board_enable == $past(i_io_wdata[0]))
    else $error("enable bit not loaded");
  AST_DO_GATE: assert property ($past(!o_board_enable) &&
    !o_board_enable |-> o_digital_out == 16'h0000)
    else $error("outputs live while disabled");
  AST_DO_LOAD: assert property (s_wr(DCCRB_OFF_DIO_LO) ##0
    o_board_enable |=> o_digital_out[7:0] == $past(i_io_wdata))
    else $error("output low byte not loaded");
  AST_TIMER: assert property (s_wr(DCCRB_OFF_TIMER_C2) |=> o_timer_wr
    && o_timer_port == 2'h2 && o_timer_wdata == $past(i_io_wdata))
    else $error("timer port 2 write wrong");
  AST_TRIG: assert property (s_wr(DCCRB_OFF_SOFT_TRIG) ##0
    i_io_wdata[0] |=> o_soft_trigger)
    else $error("trigger not pulsed");
  AST_TRIG_QUIET: assert property (!i_io_wr |=> !o_soft_trigger)
    else $error("trigger without write");
  AST_DAC: assert property (s_wr(DCCRB_OFF_CONV_HI) |=> o_dac_load &&
    o_dac_data[11:8] == $past(i_io_wdata[3:0]))
    else $error("output word not updated");
  AST_IRQ_OFF: assert property (s_wr(DCCRB_OFF_IRQ_MASK) ##0
    i_io_wdata[1:0] == 2'h0 ##1 !i_io_wr |=> !o_irq)
    else $error("line high with sources masked");
endmodule : dccrb_chk
`default_nettype wire

// >>> dccrb_host.sv
// Host processor model issuing I/O reads and writes
`timescale 1ns/1ps
`default_nettype none
module dccrb_host (
  input  wire logic        i_mclk,  // Bank clock
  input  wire logic [7:0]  i_rdata, // Read byte
  output logic [15:0]      o_addr,  // I/O address
  output logic [15:0]      o_base,  // Assigned base
  output logic             o_rd,    // Read strobe
  output logic             o_wr,    // Write strobe
  output logic [7:0]       o_wdata  // Write byte
);
  // ==========================================================
  // Idle bus; base as the firmware left it
  initial begin
    o_addr  = 16'h0000;
    o_base  = 16'h0300;
    o_rd    = 1'b0;
    o_wr    = 1'b0;
    o_wdata = 8'h00;
  end

  // One-cycle strobe; data inverted afterwards so stale bytes never match
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    @(posedge i_mclk);
    #1;
    o_addr  = o_base + {8'h00, off};
    o_wdata = d;
    o_wr    = 1'b1;
    @(posedge i_mclk);
    #1;
    o_wr    = 1'b0;
    o_wdata = ~d;
  endtask : wr

  // Absolute address so a miss below the base can be issued
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    #1;
    o_addr = a;
    o_rd   = 1'b1;
    @(posedge i_mclk);
    #1;
    o_rd = 1'b0;
    d    = i_rdata;
  endtask : rd

  // Reassignment is allowed, the card follows it
  task automatic set_base(input logic [15:0] b);
    o_base = b;
  endtask : set_base
endmodule : dccrb_host
`default_nettype wire

// >>> dccrb_irq_if.sv
// Carrier between the register bank and its interrupt unit
`timescale 1ns/1ps
`default_nettype none
interface dccrb_irq_if;
  logic       mask_wr;   // Write strobe, mask register
  logic       pol_wr;    // Write strobe, polarity register
  logic [7:0] wdata;     // Host write byte
  logic [1:0] mask;      // Enable bits, source 1..0
  logic [1:0] pol;       // Pass bits, source 1..0
  logic [1:0] src;       // Filtered source levels
  modport bank (output mask_wr, output pol_wr, output wdata,
                input mask, input pol, input src);
  modport unit (input mask_wr, input pol_wr, input wdata,
                output mask, output pol, output src);
endinterface : dccrb_irq_if
`default_nettype wire

// >>> dccrb_irq_unit.sv
// Interrupt mask, polarity and source filter of the control bank
`timescale 1ns/1ps
`default_nettype none
module dccrb_irq_unit
  import dccrb_pkg::*;
(
  input  wire logic   i_mclk,            // System clock
  input  wire logic   i_rst_n,           // Async reset, active low
  input  wire logic   i_irq_source_0,    // Source 0 pin
  input  wire logic   i_irq_source_1,    // Source 1 pin
  dccrb_irq_if.unit   bus,               // Bank side
  output logic        o_irq              // Host interrupt line
);

  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] s3_q;
  logic [1:0] src_q;
  logic [1:0] mask_q;
  logic [1:0] pol_q;
  logic [1:0] shaped;

  // ==========================================================
  // Three-stage pin synchroniser; a level counts once stages 2 and 3 agree
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q  <= 2'h0;
      s2_q  <= 2'h0;
      s3_q  <= 2'h0;
      src_q <= 2'h0;
    end else begin
      s1_q <= {i_irq_source_1, i_irq_source_0};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < DCCRB_IRQ_BITS; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          src_q[i] <= s3_q[i];
        end
      end
    end
  end

  // ==========================================================
  // Mask and polarity registers, only bits 1..0 are kept
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_q <= DCCRB_RST_MASK;
      pol_q  <= DCCRB_RST_POL;
    end else begin
      if (bus.mask_wr) begin
        mask_q <= bus.wdata[1:0];
      end
      if (bus.pol_wr) begin
        pol_q <= bus.wdata[1:0];
      end
    end
  end

  // Zero in a polarity bit inverts the source, one passes it
  assign shaped = (src_q & pol_q) | (~src_q & ~pol_q);

  // Registered OR of enabled, shaped sources
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(shaped & mask_q);
    end
  end

  assign bus.mask = mask_q;
  assign bus.pol  = pol_q;
  assign bus.src  = src_q;

endmodule : dccrb_irq_unit
`default_nettype wire

// >>> dccrb_pkg.sv
// Shared offsets, field positions and reset values of the control bank
package dccrb_pkg;

  // ==========================================================
  // Byte offsets from the assigned I/O base address
  localparam logic [7:0] DCCRB_OFF_BOARD_EN   = 8'h00;
  localparam logic [7:0] DCCRB_OFF_EXT_CTRL   = 8'h02;
  localparam logic [7:0] DCCRB_OFF_EE_DATA    = 8'h03;
  localparam logic [7:0] DCCRB_OFF_IRQ_MASK   = 8'h05;
  localparam logic [7:0] DCCRB_OFF_PIN_STAT   = 8'h07;
  localparam logic [7:0] DCCRB_OFF_IRQ_POL    = 8'h2a;
  localparam logic [7:0] DCCRB_OFF_TIMER_C0   = 8'hc0;
  localparam logic [7:0] DCCRB_OFF_TIMER_C1   = 8'hc4;
  localparam logic [7:0] DCCRB_OFF_TIMER_C2   = 8'hc8;
  localparam logic [7:0] DCCRB_OFF_TIMER_CW   = 8'hcc;
  localparam logic [7:0] DCCRB_OFF_CONV_LO    = 8'hd0;
  localparam logic [7:0] DCCRB_OFF_CONV_HI    = 8'hd4;
  localparam logic [7:0] DCCRB_OFF_DIO_LO     = 8'hd8;
  localparam logic [7:0] DCCRB_OFF_DIO_HI     = 8'hdc;
  localparam logic [7:0] DCCRB_OFF_GAIN_SEL   = 8'he0;
  localparam logic [7:0] DCCRB_OFF_CONV_MODE  = 8'he4;
  localparam logic [7:0] DCCRB_OFF_SOFT_TRIG  = 8'he8;
  localparam logic [7:0] DCCRB_OFF_CONV_STAT  = 8'hec;

  // ==========================================================
  // Field positions
  localparam int DCCRB_BOARD_EN_BIT  = 0;
  localparam int DCCRB_SOFT_TRIG_BIT = 0;
  localparam int DCCRB_IRQ_BITS      = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] DCCRB_RST_BYTE   = 8'h00;
  localparam logic [1:0] DCCRB_RST_MASK   = 2'h0;
  localparam logic [1:0] DCCRB_RST_POL    = 2'h0;
  localparam logic [11:0] DCCRB_RST_DAC   = 12'h000;
  localparam logic [15:0] DCCRB_RST_DOUT  = 16'h0000;

  // Offset of an access from the base, and whether it falls in the window
  function automatic logic [16:0] dccrb_rel(input logic [15:0] addr,
                                           input logic [15:0] base);
    logic [15:0] diff;
    diff = addr - base;
    dccrb_rel = {(addr >= base) && (diff[15:8] == 8'h00), diff};
  endfunction : dccrb_rel

endpackage : dccrb_pkg
